// ==== common/adcrs_pkg.sv ====
package adcrs_pkg;
    localparam int          NUM_CHANNELS = 8;
    localparam int          CHAN_IDX_W   = 3;
    localparam int          DATA_W       = 10;
    localparam logic [7:0]  ENABLE_RESET = 8'h00;
    localparam logic [9:0]  DATA_RESET   = 10'h000;
    localparam logic [2:0]  CHAN_RESET   = 3'h0;
endpackage

// ==== verilog/adcrs_flags.sv ====
module adcrs_flags (
    // Clock and reset
    input  wire logic                                  ref_clk_in,
    input  wire logic                                  rst_in,
    // Conversion core
    input  wire logic                                  conv_done_in,
    input  wire logic [adcrs_pkg::CHAN_IDX_W-1:0]      conv_chan_in,
    input  wire logic [adcrs_pkg::DATA_W-1:0]          conv_data_in,
    // Software control
    input  wire logic [adcrs_pkg::NUM_CHANNELS-1:0]    chan_enable_set_in,
    input  wire logic [adcrs_pkg::NUM_CHANNELS-1:0]    chan_disable_in,
    input  wire logic                                  sleep_select_in,
    // Software reads
    input  wire logic                                  status_read_in,
    input  wire logic                                  last_result_read_in,
    input  wire logic                                  chan_result_read_in,
    input  wire logic [adcrs_pkg::CHAN_IDX_W-1:0]      chan_result_sel_in,
    // Status and data
    output logic [adcrs_pkg::NUM_CHANNELS-1:0]         chan_enabled_out,
    output logic [adcrs_pkg::NUM_CHANNELS-1:0]         chan_done_flag_out,
    output logic [adcrs_pkg::NUM_CHANNELS-1:0]         channel_overrun_flag_out,
    output logic                                       data_ready_flag_out,
    output logic                                       any_channel_overrun_flag_out,
    output logic [adcrs_pkg::DATA_W-1:0]               last_result_register_out,
    output logic [adcrs_pkg::CHAN_IDX_W-1:0]           last_result_chan_out,
    output logic [adcrs_pkg::DATA_W-1:0]               chan_result_data_out,
    output logic                                       sleep_active_out
);
    localparam int N = adcrs_pkg::NUM_CHANNELS;

    // Per-channel result storage
    logic [adcrs_pkg::DATA_W-1:0] channel_result_register [N];

    // Decoded events
    logic [N-1:0]                 conv_onehot;
    logic [N-1:0]                 chan_read_hit;
    logic [N-1:0]                 store_hit;
    logic                         store_any;
    logic [N-1:0]                 next_chan_enabled;

    // Flag set and clear terms
    logic [N-1:0]                 done_set;
    logic [N-1:0]                 done_clear;
    logic [N-1:0]                 chan_ovr_set;
    logic [N-1:0]                 chan_ovr_clear;
    logic                         ready_set;
    logic                         ready_clear;
    logic                         any_ovr_set;
    logic                         any_ovr_clear;

    // Sleep request waiting for a completion
    logic                         sleep_pending;

    // Completion counts if channel was enabled before any same-cycle disable
    always_comb begin
        conv_onehot = '0;
        conv_onehot[conv_chan_in] = conv_done_in;
        chan_read_hit = '0;
        chan_read_hit[chan_result_sel_in] = chan_result_read_in;
    end
    // Enable is judged before this cycle's disable, so a disabling
    // completion still counts; later completions on it are dropped
    assign store_hit = conv_onehot & chan_enabled_out;
    assign store_any = |store_hit;

    // Own result read clears that channel's done; last-result read clears done on every channel
    assign done_set   = store_hit;
    assign done_clear = chan_read_hit | {N{last_result_read_in}};

    // Completion onto a done flag not yet read is a channel overrun
    assign chan_ovr_set   = store_hit & chan_done_flag_out;
    assign chan_ovr_clear = {N{status_read_in}};

    // Channel result reads leave data ready alone
    assign ready_set   = store_any;
    assign ready_clear = last_result_read_in;

    // Judged on ready as it stood before this edge
    assign any_ovr_set   = store_any & data_ready_flag_out;
    assign any_ovr_clear = status_read_in;

    // Disable wins over a same-cycle enable
    always_comb begin
        next_chan_enabled = (chan_enabled_out | chan_enable_set_in) & ~chan_disable_in;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            chan_enabled_out <= adcrs_pkg::ENABLE_RESET;
        end else begin
            chan_enabled_out <= next_chan_enabled;
        end
    end

    // Each channel keeps its own latest result
    for (genvar g = 0; g < N; g++) begin : g_result
        always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
                channel_result_register[g] <= adcrs_pkg::DATA_RESET;
            end else if (store_hit[g]) begin
                channel_result_register[g] <= conv_data_in;
            end
        end
    end

    // Last result follows every accepted completion, disabling ones too
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            last_result_register_out <= adcrs_pkg::DATA_RESET;
            last_result_chan_out     <= adcrs_pkg::CHAN_RESET;
        end else if (store_any) begin
            last_result_register_out <= conv_data_in;
            last_result_chan_out     <= conv_chan_in;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            chan_result_data_out <= adcrs_pkg::DATA_RESET;
        end else begin
            chan_result_data_out <= channel_result_register[chan_result_sel_in];
        end
    end

    // End-of-conversion flags, one per channel
    adcrs_sticky_flag #(
        .WIDTH(N)
    ) done_flags (
        .ref_clk_in(ref_clk_in),
        .rst_in    (rst_in),
        .set_in    (done_set),
        .clear_in  (done_clear),
        .flag_out  (chan_done_flag_out)
    );

    // Overrun flags, one per channel
    adcrs_sticky_flag #(
        .WIDTH(N)
    ) chan_ovr_flags (
        .ref_clk_in(ref_clk_in),
        .rst_in    (rst_in),
        .set_in    (chan_ovr_set),
        .clear_in  (chan_ovr_clear),
        .flag_out  (channel_overrun_flag_out)
    );

    // Data ready
    adcrs_sticky_flag #(
        .WIDTH(1)
    ) ready_flag (
        .ref_clk_in(ref_clk_in),
        .rst_in    (rst_in),
        .set_in    (ready_set),
        .clear_in  (ready_clear),
        .flag_out  (data_ready_flag_out)
    );

    // General overrun
    adcrs_sticky_flag #(
        .WIDTH(1)
    ) any_ovr_flag (
        .ref_clk_in(ref_clk_in),
        .rst_in    (rst_in),
        .set_in    (any_ovr_set),
        .clear_in  (any_ovr_clear),
        .flag_out  (any_channel_overrun_flag_out)
    );

    // Requested setting, one cycle behind the pin
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sleep_pending <= 1'b0;
        end else begin
            sleep_pending <= sleep_select_in;
        end
    end

    // Taken over only at a completion, so an idle converter never sleeps early
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sleep_active_out <= 1'b0;
        end else if (conv_done_in) begin
            sleep_active_out <= sleep_pending;
        end
    end
endmodule

// Sticky flag bank: a set in the same cycle as a clear wins,
// so no completion is lost to a coinciding software access.
// Costs no more gates per bit than a plain clear-priority flag.
module adcrs_sticky_flag #(
    // Number of flags in the bank
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    // Events
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clear_in,
    // Flags
    output logic      [WIDTH-1:0] flag_out
);
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_out <= '0;
        end else begin
            flag_out <= (flag_out & ~clear_in) | set_in;
        end
    end
endmodule

// ==== tb/adcrs_flags_props.sv ====
module adcrs_flags_props (
    input wire logic ref_clk_in, rst_in, conv_done_in, status_read_in, last_result_read_in,
    input wire logic [2:0] conv_chan_in, input wire logic [7:0] chan_enabled_out, chan_done_flag_out,
    input wire logic data_ready_flag_out, any_channel_overrun_flag_out, sleep_active_out,
    input wire logic [7:0] channel_overrun_flag_out, input wire logic [9:0] conv_data_in, last_result_register_out
);
    timeunit 1ns / 1ps;
    wire hit = conv_done_in && chan_enabled_out[conv_chan_in];
    wire rd = data_ready_flag_out, lr = last_result_read_in, gv = any_channel_overrun_flag_out;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    a_ready_set: assert property (hit |=> rd) else $error("ready not set");
    a_ready_kept: assert property (rd && !lr |=> rd) else $error("ready lost");
    a_ready_clear: assert property (lr && !hit |=> !rd) else $error("ready kept");
    a_ovr_set: assert property (hit && rd |=> gv) else $error("overrun missed");
    a_ovr_clear: assert property (status_read_in && !(hit && rd) |=> !gv) else $error("overrun kept");
    a_done_set: assert property (hit |=> chan_done_flag_out[$past(conv_chan_in)]) else $error("done missed");
    a_done_clear: assert property (lr && !hit |=> chan_done_flag_out == 8'h00) else $error("done kept");
    a_sleep_hold: assert property (!conv_done_in [*2] |=> $stable(sleep_active_out)) else $error("sleep moved");
    a_chan_ovr_set: assert property (
        hit && chan_done_flag_out[conv_chan_in] |=> channel_overrun_flag_out[$past(conv_chan_in)])
        else $error("channel overrun missed");
    a_chan_ovr_clear: assert property (
        status_read_in && !(hit && chan_done_flag_out[conv_chan_in]) |=> channel_overrun_flag_out == 8'h00)
        else $error("channel overrun kept");
    a_last_store: assert property (
        hit |=> last_result_register_out == $past(conv_data_in))
        else $error("result not stored");
    a_dead_chan: assert property (
        conv_done_in && !chan_enabled_out[conv_chan_in] && !chan_done_flag_out[conv_chan_in]
        |=> !chan_done_flag_out[$past(conv_chan_in)])
        else $error("disabled channel flagged");
endmodule
bind adcrs_flags adcrs_flags_props props (.*);

// ==== tb/adcrs_core_model.sv ====
module adcrs_core_model (
    input wire logic ref_clk_in, start_in, input wire logic [2:0] chan_in,
    output logic done_out = 1'b0, output logic [2:0] chan_out = 3'h0
);
    timeunit 1ns / 1ps;
    always @(posedge ref_clk_in) begin
        done_out <= start_in;
        chan_out <= start_in ? chan_in : ~chan_out; // Toggles when idle, so the last index returns every second idle cycle
    end
endmodule

// ==== tb/adc_result_status_flags_tb.sv ====
module adc_result_status_flags_tb;
    timeunit 1ns / 1ps;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, conv_done_in, sleep_select_in = 1'b0, go = 1'b0, chk = 1'b0;
    logic status_read_in = 1'b0, last_result_read_in = 1'b0, chan_result_read_in = 1'b0, sleep_active_out;
    logic data_ready_flag_out, any_channel_overrun_flag_out;
    logic [2:0] conv_chan_in, chan_result_sel_in = 3'h0, last_result_chan_out;
    logic [9:0] conv_data_in = 10'h000, last_result_register_out, chan_result_data_out, lr_m = 10'h000, crx;
    logic [9:0] rm[8] = '{default: 10'h000};
    logic [49:0] ex, got, q[$];
    logic [7:0] en_m = 8'h00, co_m = 8'h00, dprev = 8'h00;
    logic [2:0] lc_m = 3'h0, pch = 3'h0;
    logic pend = 1'b0, sp_m = 1'b0, slp_m = 1'b0;
    logic [7:0] chan_enable_set_in = 8'hff, chan_disable_in = 8'h00, chan_enabled_out, chan_done_flag_out;
    logic [7:0] channel_overrun_flag_out;
    int bad_count = 0, checks = 0;
    // Op, channel, expected {ready, overrun, done}
    logic [23:0] tbl[18] = '{24'h00_0000, 24'h10_2000, 24'h10_5204, 24'h08_0324, 24'h08_0224,
        24'h10_5224, 24'h02_1324, 24'h04_0100, 24'h10_3100, 24'h08_0208, 24'h10_3208,
        24'h01_1308, 24'h10_1308, 24'h02_3300, 24'h10_1300, 24'h04_0100, 24'h10_6100, 24'h04_0340};
    assign got = {last_result_chan_out, last_result_register_out, chan_result_data_out, chan_enabled_out,
        channel_overrun_flag_out, sleep_active_out, data_ready_flag_out, any_channel_overrun_flag_out,
        chan_done_flag_out};
    adcrs_core_model core (.ref_clk_in(ref_clk_in), .start_in(go), .chan_in(chan_result_sel_in),
        .done_out(conv_done_in), .chan_out(conv_chan_in));
    adcrs_flags dut (
        .ref_clk_in                  (ref_clk_in),
        .rst_in                      (rst_in),
        .conv_done_in                (conv_done_in),
        .conv_chan_in                (conv_chan_in),
        .conv_data_in                (conv_data_in),
        .chan_enable_set_in          (chan_enable_set_in),
        .chan_disable_in             (chan_disable_in),
        .sleep_select_in             (sleep_select_in),
        .status_read_in              (status_read_in),
        .last_result_read_in         (last_result_read_in),
        .chan_result_read_in         (chan_result_read_in),
        .chan_result_sel_in          (chan_result_sel_in),
        .chan_enabled_out            (chan_enabled_out),
        .chan_done_flag_out          (chan_done_flag_out),
        .channel_overrun_flag_out    (channel_overrun_flag_out),
        .data_ready_flag_out         (data_ready_flag_out),
        .any_channel_overrun_flag_out(any_channel_overrun_flag_out),
        .last_result_register_out    (last_result_register_out),
        .last_result_chan_out        (last_result_chan_out),
        .chan_result_data_out        (chan_result_data_out),
        .sleep_active_out            (sleep_active_out)
    );
    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (chk) begin
        #2 ex = q.pop_front();
        checks++;
        bad_count += int'(got !== ex);
        if (got !== ex) $display("MISMATCH %0t got %h exp %h", $time, got, ex);
    end
    task automatic stop_test();
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'ha388_9fc2));
        repeat (20) @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        foreach (tbl[i]) begin
            {go, status_read_in, last_result_read_in, chan_result_read_in, chk} = {tbl[i][20:17], 1'b1};
            {chan_enable_set_in, chan_result_sel_in} = {(i == 0) ? 8'hff : 8'h00, tbl[i][14:12]};
            chan_disable_in = 8'(tbl[i][16]) << tbl[i][14:12];
            {conv_data_in, sleep_select_in} = 11'($urandom);
            // Reference model of this edge, built from the rules; ready, overrun and done come from the table
            crx = rm[chan_result_sel_in];
            if (status_read_in) co_m = 8'h00;
            if (pend) slp_m = sp_m;
            if (pend && en_m[pch]) begin
                {lr_m, lc_m, rm[pch]} = {conv_data_in, pch, conv_data_in};
                co_m[pch] = co_m[pch] | dprev[pch];
            end
            sp_m = sleep_select_in;
            en_m = (en_m | chan_enable_set_in) & ~chan_disable_in;
            {pend, pch, dprev} = {go, chan_result_sel_in, tbl[i][7:0]};
            q.push_back({lc_m, lr_m, crx, en_m, co_m, slp_m, tbl[i][9:0]});
            @(posedge ref_clk_in) #1;
        end
        {go, status_read_in, last_result_read_in, chan_result_read_in, chk, chan_disable_in} = 13'h0000;
        #2 stop_test();
    end
endmodule
